/* rtl/lpmc_ctrl.sv */
/*
  lpmc_ctrl: low power mode controller. Holds the power control register
  and the suspend bit, sequences run, idle, stop and suspend, and drives
  the clock gates of the cpu, oscillators and peripherals.
  assumes: the cpu core raises instr_done at the end of each instruction
  and reads sfr data one cycle after rd; external wake inputs are
  asynchronous pins and are synchronised here.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - idle gates cpu clock only after the writing instruction completes
// - idle keeps state and keeps timer, interrupt, serial, analog clocks
// - enabled interrupt in idle clears idle bit and restarts cpu
// - reset ending low power runs normal reset, vector 0x0000
// - watchdog keeps counting in idle and its reset ends idle
// - stop halts internal oscillator, cpu, digital peripherals after write
// - stop keeps interrupts and timers off except missing clock detector
// - stop ends only by reset
// - enabled missing clock detector resets device after 100 us stop
// - suspend bit halts cpu and fast oscillator after write completes
// - suspend retains state; only port match logic keeps running; int_osc_en also stays on in suspend
// - suspend ends on port match, enabled comparator low, or reset
// - non-reset suspend wake resumes next instruction, interrupt first
// - stop and idle bits always read as zero
// - bits 7:2 are six plain read/write flags reset to zero
module lpmc_ctrl #(
  parameter int MCD_CYCLES = lpmc_pkg::LPMC_MCD_CYCLES
) (
  // clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  // sfr bus from the cpu core
  input  wire lpmc_pkg::lpmc_sfr_req_t sfr_req,
  input  wire logic                   instr_done,
  output logic [7:0]                  sfr_rdata,
  // wake and reset sources
  input  wire lpmc_pkg::lpmc_wake_t   wake_in,
  input  wire logic                   watchdog_reset,
  input  wire logic                   mcd_enable,
  // outputs toward the chip
  output lpmc_pkg::lpmc_gates_t       gates,
  output logic                        mcd_reset_req,
  output logic                        wake_irq_req,
  output logic [15:0]                 reset_vector,
  output lpmc_pkg::lpmc_state_t       mode
);
  import lpmc_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  lpmc_state_t state_reg;
  lpmc_state_t state_next;
  logic [5:0]  flags_reg;
  logic [7:0]  osc_reg;
  logic        idle_arm_reg;
  logic        stop_arm_reg;
  logic        susp_arm_reg;
  lpmc_wake_t  wake_s1_reg;
  lpmc_wake_t  wake_s2_reg;
  logic        mcd_timeout;
  logic        pc_wr;
  logic        osc_wr;
  logic        susp_wake;

  function automatic logic hit(input lpmc_sfr_req_t r, input logic [7:0] a);
    hit = r.addr == a;
  endfunction

  assign pc_wr  = sfr_req.wr && hit(sfr_req, LPMC_POWER_CONTROL_ADDR);
  assign osc_wr = sfr_req.wr && hit(sfr_req, LPMC_OSC_CONTROL_ADDR);

  // ****************************************************************
  // wake pin synchronisers
  // ****************************************************************
  // pins from other blocks may be asynchronous while the core is gated
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_s1_reg <= '0;
      wake_s2_reg <= '0;
    end else if (clk_en) begin
      wake_s1_reg <= wake_in;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  // besides reset, only port match or an enabled comparator low can end suspend
  assign susp_wake = wake_s2_reg.port_match ||
                     (wake_s2_reg.cmp_low && wake_s2_reg.cmp_wake_en);

  // ****************************************************************
  // power control register
  // ****************************************************************
  // mode bits are write-to-trigger: they arm entry, never store for reads
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg    <= LPMC_POWER_CONTROL_RST[LPMC_FLAGS_MSB:LPMC_FLAGS_LSB];
      idle_arm_reg <= 1'b0;
      stop_arm_reg <= 1'b0;
    end else if (clk_en) begin
      if (pc_wr) begin
        flags_reg    <= sfr_req.wdata[LPMC_FLAGS_MSB:LPMC_FLAGS_LSB];
        stop_arm_reg <= sfr_req.wdata[LPMC_STOP_BIT];
        // stop wins over idle when both are written together
        idle_arm_reg <= sfr_req.wdata[LPMC_IDLE_BIT] &&
                        !sfr_req.wdata[LPMC_STOP_BIT];
      end else if (instr_done) begin
        idle_arm_reg <= 1'b0;
        stop_arm_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // oscillator control register, suspend bit
  // ****************************************************************
  // suspend bit self-clears on wake so software sees the exit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_reg      <= LPMC_OSC_CONTROL_RST;
      susp_arm_reg <= 1'b0;
    end else if (clk_en) begin
      if (osc_wr) begin
        osc_reg      <= sfr_req.wdata;
        susp_arm_reg <= sfr_req.wdata[LPMC_SUSPEND_BIT];
      end else begin
        if (instr_done) begin
          susp_arm_reg <= 1'b0;
        end
        if (state_reg == LPMC_SUSPEND && susp_wake) begin
          osc_reg[LPMC_SUSPEND_BIT] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // idle and stop positions always read as zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en) begin
      if (sfr_req.rd && hit(sfr_req, LPMC_POWER_CONTROL_ADDR)) begin
        sfr_rdata <= {flags_reg, 2'b00};
      end else if (sfr_req.rd && hit(sfr_req, LPMC_OSC_CONTROL_ADDR)) begin
        sfr_rdata <= osc_reg;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // mode sequencer
  // ****************************************************************
  // entry waits for instr_done so the writing instruction finishes first
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LPMC_RUN: begin
        if (instr_done && stop_arm_reg) begin
          state_next = LPMC_STOP;
        end else if (instr_done && idle_arm_reg) begin
          state_next = LPMC_IDLE;
        end else if (instr_done && susp_arm_reg) begin
          state_next = LPMC_SUSPEND;
        end
      end
      LPMC_IDLE: begin
        if (wake_s2_reg.irq_pending) begin
          state_next = LPMC_RUN;
        end
      end
      LPMC_STOP: begin
        state_next = LPMC_STOP;
      end
      LPMC_SUSPEND: begin
        if (susp_wake) begin
          state_next = LPMC_RUN;
        end
      end
    endcase
  end

  // watchdog and detector resets arrive as the async reset of the core;
  // watchdog_reset is also honoured here so idle ends even if it is late
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= LPMC_RUN;
    end else if (clk_en) begin
      if (watchdog_reset) begin
        state_reg <= LPMC_RUN;
      end else begin
        state_reg <= state_next;
      end
    end
  end

  // ****************************************************************
  // missing clock detector
  // ****************************************************************
  lpmc_wake #(
    .MCD_CYCLES (MCD_CYCLES)
  ) u_mcd (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .count_en (mcd_enable && state_reg == LPMC_STOP),
    .timeout  (mcd_timeout)
  );

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  // gates follow the next state so they change with the mode register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gates         <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      mcd_reset_req <= 1'b0;
      wake_irq_req  <= 1'b0;
      reset_vector  <= LPMC_RESET_VECTOR;
      mode          <= LPMC_RUN;
    end else if (clk_en) begin
      mode                <= watchdog_reset ? LPMC_RUN : state_next;
      gates.cpu_clk_en    <= watchdog_reset || state_next == LPMC_RUN;
      // idle keeps peripheral clocks; stop and suspend halt them
      gates.periph_clk_en <= watchdog_reset || state_next == LPMC_RUN ||
                             state_next == LPMC_IDLE;
      gates.int_osc_en    <= watchdog_reset || state_next != LPMC_STOP;
      gates.hf_osc_en     <= watchdog_reset ||
                             (state_next != LPMC_STOP && state_next != LPMC_SUSPEND);
      gates.port_match_en <= watchdog_reset || state_next != LPMC_STOP;
      mcd_reset_req       <= mcd_timeout;
      wake_irq_req        <= state_reg == LPMC_SUSPEND && susp_wake &&
                             wake_s2_reg.irq_pending;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_idle_entry;
    pc_wr && sfr_req.wdata[LPMC_IDLE_BIT] && !sfr_req.wdata[LPMC_STOP_BIT]
      && clk_en && state_reg == LPMC_RUN && !susp_arm_reg;
  endsequence

  a_idle_waits_done: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_idle_entry ##1 (!instr_done && clk_en && !watchdog_reset && !pc_wr)
      |=> state_reg == LPMC_RUN)
    else $error("idle entered before instruction completed");

  a_stop_is_final: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == LPMC_STOP && !watchdog_reset |=> state_reg == LPMC_STOP)
    else $error("stop left without reset");

  a_idle_irq_wake: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == LPMC_IDLE && wake_s2_reg.irq_pending && clk_en
      |=> state_reg == LPMC_RUN ##1 !clk_en || gates.cpu_clk_en)
    else $error("interrupt did not wake from idle");

  a_read_zero_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    sfr_req.rd && clk_en && hit(sfr_req, LPMC_POWER_CONTROL_ADDR)
      |=> sfr_rdata[LPMC_STOP_BIT:LPMC_IDLE_BIT] == 2'b00 &&
          sfr_rdata[LPMC_FLAGS_MSB:LPMC_FLAGS_LSB] == $past(flags_reg))
    else $error("power control read wrong");

  a_flags_store: assert property (@(posedge core_clk) disable iff (!reset_n)
    pc_wr && clk_en |=> flags_reg == $past(sfr_req.wdata[LPMC_FLAGS_MSB:LPMC_FLAGS_LSB]))
    else $error("general flags not stored");

  a_both_pick_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
    pc_wr && clk_en && sfr_req.wdata[LPMC_STOP_BIT] |=> !idle_arm_reg && stop_arm_reg)
    else $error("stop did not win over idle");

  a_stop_gates_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == LPMC_STOP && clk_en && !watchdog_reset
      |=> !gates.cpu_clk_en && !gates.int_osc_en && !gates.periph_clk_en)
    else $error("stop left clocks running");

  a_idle_periph_on: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == LPMC_IDLE |-> gates.periph_clk_en && !gates.cpu_clk_en)
    else $error("idle gating wrong");

  a_suspend_wake_src: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == LPMC_SUSPEND && !susp_wake && !watchdog_reset |=> state_reg == LPMC_SUSPEND)
    else $error("suspend left without a wake source");

  a_mcd_timeout: assert property (@(posedge core_clk) disable iff (!reset_n)
    mcd_timeout && clk_en |=> mcd_reset_req)
    else $error("detector timeout not raised");

endmodule
`default_nettype wire

/* rtl/lpmc_pkg.sv */
/*
  lpmc_pkg: constants, field layouts and types shared by the low power
  mode controller and its wake unit.
  assumes: one system clock, an 8-bit special function register bus
  driven by the cpu core in the same clock domain.
*/
package lpmc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] LPMC_POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] LPMC_POWER_CONTROL_RST  = 8'h00;
  localparam logic [7:0] LPMC_OSC_CONTROL_ADDR   = 8'hb2;  // arbitrary placement
  localparam logic [7:0] LPMC_OSC_CONTROL_RST    = 8'h00;
  localparam int         LPMC_IDLE_BIT           = 0;
  localparam int         LPMC_STOP_BIT           = 1;
  localparam int         LPMC_FLAGS_LSB          = 2;
  localparam int         LPMC_FLAGS_MSB          = 7;
  localparam int         LPMC_SUSPEND_BIT        = 5;
  localparam logic [15:0] LPMC_RESET_VECTOR      = 16'h0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int LPMC_CLK_MHZ        = 200;
  localparam int LPMC_MCD_TIMEOUT_US = 100;
  localparam int LPMC_MCD_CYCLES     = LPMC_MCD_TIMEOUT_US * LPMC_CLK_MHZ;
  localparam int LPMC_MCD_W          = 15;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    LPMC_RUN,
    LPMC_IDLE,
    LPMC_STOP,
    LPMC_SUSPEND
  } lpmc_state_t;

  // special function register access from the cpu core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lpmc_sfr_req_t;

  // wake sources gathered from neighbouring blocks
  typedef struct packed {
    logic irq_pending;
    logic port_match;
    logic cmp_low;
    logic cmp_wake_en;
  } lpmc_wake_t;

  // clock gates toward the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic int_osc_en;
    logic hf_osc_en;
    logic port_match_en;
  } lpmc_gates_t;

endpackage

/* rtl/lpmc_wake.sv */
/*
  lpmc_wake: missing clock detector timeout counter used while the
  controller sits in stop.
  assumes: same clock as the controller; the timeout is a parameter so
  a simulation can shorten it.
*/
`timescale 1ns/10ps
`default_nettype none
module lpmc_wake #(
  parameter int MCD_CYCLES = lpmc_pkg::LPMC_MCD_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // control
  input  wire logic count_en,
  // result
  output logic      timeout
);
  import lpmc_pkg::*;

  logic [LPMC_MCD_W-1:0] count_reg;

  // counter runs only while armed; reaching the limit raises timeout
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      timeout   <= 1'b0;
    end else if (clk_en) begin
      if (!count_en) begin
        count_reg <= '0;
        timeout   <= 1'b0;
      end else if (count_reg == LPMC_MCD_W'(MCD_CYCLES - 1)) begin
        timeout <= 1'b1;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* tb/lpmc_cpu_model.sv */
/*
  lpmc_cpu_model: behavioural cpu core facing the controller. It makes sfr
  cycles and instruction-complete pulses, and stands for software duties.
  assumes: the bench calls its tasks; signals change on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module lpmc_cpu_model (
  // clock
  input  wire logic               core_clk,
  // bus toward the controller
  output var lpmc_pkg::lpmc_sfr_req_t sfr_req,
  output logic                    instr_done,
  input  wire logic [7:0]         sfr_rdata
);
  import lpmc_pkg::*;
  logic zero_tempco_enable;  // stands for the reference control bit

  // ****************************************************************
  // bus cycles
  // ****************************************************************
  // quiet bus at time zero
  initial begin
    sfr_req = '0;
    instr_done = 1'b0;
    zero_tempco_enable = 1'b0;
  end

  // one write, held over one taking edge; released lines show the inverse
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge core_clk);
    sfr_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  // read data is registered on the taking edge and sampled at the next falling edge
  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge core_clk);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge core_clk);
    sfr_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
    data = sfr_rdata;
  endtask

  // end of the instruction that wrote a control bit
  task automatic finish_instr();
    @(negedge core_clk);
    instr_done = 1'b1;
    @(negedge core_clk);
    instr_done = 1'b0;
  endtask

  // software duty before suspend
  task automatic prepare_suspend();
    zero_tempco_enable = 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
  testbench: self-checking bench for lpmc_ctrl with a cpu model.
  assumes: the missing clock timeout is shortened to MISSING_CLOCK_DETECTOR cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lpmc_pkg::*;
  localparam int MISSING_CLOCK_DETECTOR = 20;
  logic          core_clk, reset_n, clk_en, watchdog_reset, mcd_enable;
  logic          instr_done, mcd_reset_req, wake_irq_req, irq_seen;
  logic [7:0]    sfr_rdata, rd;
  logic [15:0]   reset_vector;
  lpmc_wake_t    wake_in;
  lpmc_sfr_req_t sfr_req;
  lpmc_gates_t   gates;
  lpmc_state_t   mode;
  int            mismatches = 0;
  int            compares = 0;

  lpmc_ctrl #(.MCD_CYCLES(MISSING_CLOCK_DETECTOR)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .sfr_req(sfr_req), .instr_done(instr_done),
    .sfr_rdata(sfr_rdata), .wake_in(wake_in), .watchdog_reset(watchdog_reset),
    .mcd_enable(mcd_enable), .gates(gates), .mcd_reset_req(mcd_reset_req),
    .wake_irq_req(wake_irq_req), .reset_vector(reset_vector), .mode(mode));
  lpmc_cpu_model cpu (.core_clk(core_clk), .sfr_req(sfr_req),
    .instr_done(instr_done), .sfr_rdata(sfr_rdata));

  // ****************************************************************
  // clock and helpers
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // the wake pulse lasts one cycle, so it is caught here
  always @(posedge core_clk) if (wake_irq_req === 1'b1) irq_seen <= 1'b1;

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // bounded wait for a mode, then compare
  task automatic wait_mode(input lpmc_state_t m, input int n, input string msg);
    for (int i = 0; i < n && mode !== m; i++) @(negedge core_clk);
    chk(mode === m, msg);
  endtask

  task automatic hold_mode(input lpmc_state_t m, input int n, input string msg);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge core_clk);
      ok &= (mode === m);
    end
    chk(ok, msg);
  endtask

  task automatic do_reset();
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_regs();
    chk(gates === 5'h1f && mode === LPMC_RUN && reset_vector === 16'h0000, "reset");
    cpu.sfr_read(LPMC_POWER_CONTROL_ADDR, rd);
    chk(rd === 8'h00, "power control reset");
    cpu.sfr_read(8'h55, rd);
    chk(rd === 8'h00, "unmapped read");
    cpu.sfr_write(LPMC_POWER_CONTROL_ADDR, 8'ha8);
    cpu.sfr_read(LPMC_POWER_CONTROL_ADDR, rd);
    chk(rd === 8'ha8, "flags read back");
    $display("test_regs done");
  endtask

  task automatic test_idle();
    cpu.sfr_write(LPMC_POWER_CONTROL_ADDR, 8'hfd);
    cpu.sfr_read(LPMC_POWER_CONTROL_ADDR, rd);
    chk(rd === 8'hfc, "idle bit reads zero");
    chk(mode === LPMC_RUN && gates.cpu_clk_en === 1'b1, "early idle");
    cpu.finish_instr();
    chk(mode === LPMC_IDLE && gates.cpu_clk_en === 1'b0, "idle entry");
    chk(gates.periph_clk_en === 1'b1, "idle peripherals run");
    hold_mode(LPMC_IDLE, 5, "idle holds");
    // a low clock enable freezes the synchronisers and the sequencer
    clk_en = 1'b0;
    wake_in.irq_pending = 1'b1;
    hold_mode(LPMC_IDLE, 4, "frozen while disabled");
    clk_en = 1'b1;
    wait_mode(LPMC_RUN, 4, "irq wakes idle");
    chk(gates.cpu_clk_en === 1'b1, "cpu restarts");
    wake_in.irq_pending = 1'b0;
    // two-byte dummy after the idle write: read and write back
    cpu.sfr_read(LPMC_POWER_CONTROL_ADDR, rd);
    cpu.sfr_write(LPMC_POWER_CONTROL_ADDR, rd);
    cpu.sfr_read(LPMC_POWER_CONTROL_ADDR, rd);
    chk(rd === 8'hfc && mode === LPMC_RUN, "flags kept, no reentry");
    $display("test_idle done");
  endtask

  task automatic test_watchdog();
    cpu.sfr_write(LPMC_POWER_CONTROL_ADDR, 8'h01);
    cpu.finish_instr();
    chk(mode === LPMC_IDLE, "idle again");
    watchdog_reset = 1'b1;
    @(negedge core_clk);
    watchdog_reset = 1'b0;
    wait_mode(LPMC_RUN, 3, "watchdog ends idle");
    do_reset();
    cpu.sfr_read(LPMC_POWER_CONTROL_ADDR, rd);
    chk(rd === 8'h00 && reset_vector === 16'h0000, "reset clears");
    $display("test_watchdog done");
  endtask

  task automatic test_stop();
    mcd_enable = 1'b0;
    cpu.sfr_write(LPMC_POWER_CONTROL_ADDR, 8'h03);
    cpu.finish_instr();
    chk(mode === LPMC_STOP, "stop wins over idle");
    chk(gates.cpu_clk_en === 1'b0 && gates.int_osc_en === 1'b0, "stop halts");
    chk(gates.periph_clk_en === 1'b0, "stop peripherals off");
    wake_in = '{irq_pending: 1'b1, port_match: 1'b1, cmp_low: 1'b1, cmp_wake_en: 1'b1};
    hold_mode(LPMC_STOP, 12, "no wake from stop");
    chk(mcd_reset_req === 1'b0, "detector off");
    wake_in = '0;
    do_reset();
    chk(mode === LPMC_RUN && gates === 5'h1f, "reset ends stop");
    $display("test_stop done");
  endtask

  task automatic test_mcd();
    int n;
    mcd_enable = 1'b1;
    cpu.sfr_write(LPMC_POWER_CONTROL_ADDR, 8'h02);
    cpu.finish_instr();
    for (n = 0; n < 3 * MISSING_CLOCK_DETECTOR && mcd_reset_req !== 1'b1; n++) @(negedge core_clk);
    chk(n >= MISSING_CLOCK_DETECTOR - 1 && n <= MISSING_CLOCK_DETECTOR + 3, "detector timeout");
    do_reset();
    mcd_enable = 1'b0;
    $display("test_mcd done");
  endtask

  task automatic test_suspend();
    cpu.prepare_suspend();
    cpu.sfr_write(LPMC_OSC_CONTROL_ADDR, 8'h20);
    cpu.finish_instr();
    chk(mode === LPMC_SUSPEND && gates.hf_osc_en === 1'b0, "suspend");
    chk(gates.cpu_clk_en === 1'b0 && gates.port_match_en === 1'b1, "match runs");
    wake_in = '{irq_pending: 1'b1, port_match: 1'b0, cmp_low: 1'b1, cmp_wake_en: 1'b0};
    hold_mode(LPMC_SUSPEND, 8, "irq or masked comparator ignored");
    irq_seen = 1'b0;
    wake_in.port_match = 1'b1;
    wait_mode(LPMC_RUN, 6, "port match wakes");
    repeat (2) @(negedge core_clk);
    chk(irq_seen === 1'b1, "wake interrupt");
    wake_in = '0;
    cpu.sfr_read(LPMC_OSC_CONTROL_ADDR, rd);
    chk(rd === 8'h00, "suspend bit cleared");
    cpu.sfr_write(LPMC_OSC_CONTROL_ADDR, 8'h20);
    cpu.finish_instr();
    irq_seen = 1'b0;
    wake_in = '{irq_pending: 1'b0, port_match: 1'b0, cmp_low: 1'b1, cmp_wake_en: 1'b1};
    wait_mode(LPMC_RUN, 6, "comparator wakes");
    repeat (2) @(negedge core_clk);
    chk(irq_seen === 1'b0, "no wake interrupt");
    wake_in = '0;
    $display("test_suspend done");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;  // runs enabled; test_idle freezes it briefly
    watchdog_reset = 1'b0;
    mcd_enable = 1'b0;
    wake_in = '0;
    irq_seen = 1'b0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    test_regs();
    test_idle();
    test_watchdog();
    test_stop();
    test_mcd();
    test_suspend();
    wrap_up();
  end

  // the tests need under two hundred cycles; 4000 leaves ample margin
  initial begin
    #(4000 * 5);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
